/* rtl/tbtc_defines.svh */
// Offsets, field positions, reset values and counts of the touch channel configuration block.
`ifndef TBTC_DEFINES_SVH
`define TBTC_DEFINES_SVH
`define TBTC_IDX_CFGC     16'hA01A
`define TBTC_IDX_BASE     16'hA020
`define TBTC_IDX_THD      16'hA021
`define TBTC_IDX_STATUS   16'hA022
`define TBTC_IDX_CTRL     16'hA023
`define TBTC_IDX_DUTY     16'hA024
`define TBTC_CFGC_RESET   8'h00
`define TBTC_WORD_RESET   16'h0000
`define TBTC_CFG_DEPTH_LSB 6
`define TBTC_CFG_LEN_LSB   3
`define TBTC_ST_NOISE     0
`define TBTC_ST_BUSY      1
`define TBTC_ST_TRIP      2
`define TBTC_CTL_AUTO     0
`define TBTC_CTL_START    1
`define TBTC_CTL_REPEAT_LSB 2
`define TBTC_AVG_MIN_SHIFT 5
`define TBTC_LEN_12K      17'h0_3000
`define TBTC_LEN_16K      17'h0_4000
`define TBTC_LEN_32K      17'h0_8000
`define TBTC_LEN_64K      17'h1_0000
`define TBTC_LEN_1K       17'h0_0400
`endif

/* rtl/tbtc_pkg.sv */
// Types shared by the touch channel configuration block.
package tbtc_pkg;
    typedef struct packed {
        logic [1:0] avg_depth;
        logic [2:0] seq_len;
        logic       seed_from_first_sample;
        logic       relative_threshold_select;
        logic       auto_noise_filter_enable;
    } tbtc_cfg_t;

    typedef struct packed {
        logic       sense;
        logic       noise;
    } tbtc_fe_t;

    typedef enum logic [1:0] {
        TBTC_IDLE = 2'b00,
        TBTC_RUN  = 2'b01,
        TBTC_DONE = 2'b11
    } tbtc_state_t;
endpackage

/* rtl/tbtc_top.sv */
// Touch channel configuration, conversion counter, baseline average and threshold compare.
//
// Operation
// - One 8-bit read/write configuration register at index 0xA01A, reset to zero.
// - Averaging depth codes 00..11 select 32, 64, 128 or 256 conversions.
// - Each conversion without a pending seed folds low duty count into the baseline moving average.
// - Sequence length codes give 1024 up to 65536 cycles per sequence.
// - Every sequence uses that count; nonzero repeat setting runs more sequences.
// - A conversion ends exactly at the programmed cycle count, regardless of noise.
// - Seed set: first duty after auto entry seeds baseline; else software value.
// - Threshold select clear: compare duty with trip level alone for interrupt, wakeup.
// - Threshold select set: compare duty with trip level plus reference level.
// - Auto noise filter enable turns low-frequency filtering on in auto mode.
// - Noise status flag updates whatever the filter enable setting.
// - Noise flag set on detection, stays until software writes zero.
`timescale 1ns/1ps
`include "tbtc_defines.svh"
module tbtc_top #(
    parameter int unsigned SEQ_SHIFT = 0
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [17:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic        sense_in,
    input  wire logic        noise_in,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             trip_event,
    output logic             wake_event,
    output logic             conv_active
);
    // Sequence length in cycles; the shift only exists to shorten simulations.
    function automatic logic [16:0] seq_cycles(input logic [2:0] code);
        logic [16:0] n;
        n = `TBTC_LEN_1K;
        unique case (code)
            3'd0, 3'd1, 3'd2, 3'd3: n = `TBTC_LEN_1K << code;
            3'd4: n = `TBTC_LEN_12K;
            3'd5: n = `TBTC_LEN_16K;
            3'd6: n = `TBTC_LEN_32K;
            3'd7: n = `TBTC_LEN_64K;
        endcase
        n = n >> SEQ_SHIFT;
        return (n == 17'h0_0000) ? 17'h0_0001 : n;
    endfunction

    // Baseline moves by the difference divided by the averaging depth.
    function automatic logic [15:0] ma_step(input logic [15:0] avg, input logic [15:0] duty,
                                            input logic [1:0] depth);
        logic signed [16:0] diff;
        logic [3:0]         sh;
        diff = $signed({1'b0, duty}) - $signed({1'b0, avg});
        sh   = 4'(`TBTC_AVG_MIN_SHIFT) + {2'b00, depth};
        diff = diff >>> sh;
        return 16'($signed({1'b0, avg}) + diff);
    endfunction

    function automatic logic hit(input logic [17:0] a, input logic [15:0] idx);
        return a == {idx, 2'b00};
    endfunction

    tbtc_pkg::tbtc_cfg_t   cfg_reg;
    tbtc_pkg::tbtc_state_t state_reg;
    tbtc_pkg::tbtc_fe_t    fe_meta_reg;
    tbtc_pkg::tbtc_fe_t    fe_sync_reg;
    logic [15:0] base_reg;
    logic [15:0] thd_reg;
    logic [15:0] duty_reg;
    logic [15:0] last_duty_reg;
    logic [16:0] cyc_reg;
    logic [1:0]  seq_idx_reg;
    logic [1:0]  repeat_count_reg;
    logic        auto_reg;
    logic        start_reg;
    logic        seed_pend_reg;
    logic        noise_flag_reg;
    logic        trip_flag_reg;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic        trip_reg;
    logic        wake_reg;
    logic        active_reg;

    logic        setup;
    logic        wr_fire;
    logic        mapped;
    logic [16:0] target;
    logic        seq_end;
    logic        conv_end;
    logic        filt_on;
    logic [16:0] threshold;
    logic [15:0] duty_final;

    assign setup   = psel & ~penable;
    assign wr_fire = psel & penable & pwrite & pready_reg;
    assign mapped  = hit(paddr, `TBTC_IDX_CFGC) | hit(paddr, `TBTC_IDX_BASE)
                   | hit(paddr, `TBTC_IDX_THD) | hit(paddr, `TBTC_IDX_STATUS)
                   | hit(paddr, `TBTC_IDX_CTRL) | hit(paddr, `TBTC_IDX_DUTY);

    assign target   = seq_cycles(cfg_reg.seq_len);
    assign seq_end  = (state_reg == tbtc_pkg::TBTC_RUN) && (cyc_reg == target - 17'd1);
    assign conv_end = seq_end && (seq_idx_reg == repeat_count_reg);
    // Filtering only drops samples; the cycle counter keeps running so timing stays fixed.
    assign filt_on  = auto_reg & cfg_reg.auto_noise_filter_enable & fe_sync_reg.noise;
    assign threshold = cfg_reg.relative_threshold_select
                     ? {1'b0, thd_reg} + {1'b0, base_reg}
                     : {1'b0, thd_reg};
    assign duty_final = (!fe_sync_reg.sense && !filt_on && duty_reg != 16'hFFFF)
                      ? duty_reg + 16'd1 : duty_reg;

    // Pins are asynchronous to pclk; the first stage feeds only the second.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fe_meta_reg <= '0;
            fe_sync_reg <= '0;
        end else begin
            fe_meta_reg <= '{sense: sense_in, noise: noise_in};
            fe_sync_reg <= fe_meta_reg;
        end
    end

    // Answer in the first access cycle; an unmapped address reads zero and errors.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= '0;
        end else begin
            pready_reg  <= setup;
            pslverr_reg <= setup & ~mapped;
            if (setup) begin
                prdata_reg <= '0;
                if (hit(paddr, `TBTC_IDX_CFGC))
                    prdata_reg <= {24'h00_0000, cfg_reg};
                if (hit(paddr, `TBTC_IDX_BASE))
                    prdata_reg <= {16'h0000, base_reg};
                if (hit(paddr, `TBTC_IDX_THD))
                    prdata_reg <= {16'h0000, thd_reg};
                if (hit(paddr, `TBTC_IDX_STATUS))
                    prdata_reg <= {29'h0000_0000, trip_flag_reg,
                                   state_reg != tbtc_pkg::TBTC_IDLE, noise_flag_reg};
                if (hit(paddr, `TBTC_IDX_CTRL))
                    prdata_reg <= {28'h000_0000, repeat_count_reg, start_reg, auto_reg};
                if (hit(paddr, `TBTC_IDX_DUTY))
                    prdata_reg <= {16'h0000, last_duty_reg};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cfg_reg <= `TBTC_CFGC_RESET;
        else if (wr_fire && hit(paddr, `TBTC_IDX_CFGC))
            cfg_reg <= pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            thd_reg <= `TBTC_WORD_RESET;
        else if (wr_fire && hit(paddr, `TBTC_IDX_THD))
            thd_reg <= pwdata[15:0];
    end

    // Auto mode, one-shot start and repeat count setting.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_reg         <= 1'b0;
            start_reg        <= 1'b0;
            repeat_count_reg <= 2'b00;
        end else begin
            if (state_reg == tbtc_pkg::TBTC_RUN)
                start_reg <= 1'b0;
            if (wr_fire && hit(paddr, `TBTC_IDX_CTRL)) begin
                auto_reg         <= pwdata[`TBTC_CTL_AUTO];
                repeat_count_reg <= pwdata[`TBTC_CTL_REPEAT_LSB +: 2];
                if (pwdata[`TBTC_CTL_START])
                    start_reg <= 1'b1;
            end
        end
    end

    // Seeding is armed when auto mode is entered and consumed by the next result.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            seed_pend_reg <= 1'b0;
        else if (wr_fire && hit(paddr, `TBTC_IDX_CTRL) && pwdata[`TBTC_CTL_AUTO] && !auto_reg)
            seed_pend_reg <= cfg_reg.seed_from_first_sample;
        else if (conv_end)
            seed_pend_reg <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= tbtc_pkg::TBTC_IDLE;
        end else begin
            unique case (state_reg)
                tbtc_pkg::TBTC_IDLE:
                    if (auto_reg || start_reg)
                        state_reg <= tbtc_pkg::TBTC_RUN;
                tbtc_pkg::TBTC_RUN:
                    if (conv_end)
                        state_reg <= tbtc_pkg::TBTC_DONE;
                tbtc_pkg::TBTC_DONE:
                    state_reg <= tbtc_pkg::TBTC_IDLE;
                default:
                    state_reg <= tbtc_pkg::TBTC_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_reg     <= '0;
            seq_idx_reg <= 2'b00;
            duty_reg    <= `TBTC_WORD_RESET;
        end else if (state_reg != tbtc_pkg::TBTC_RUN) begin
            cyc_reg     <= '0;
            seq_idx_reg <= 2'b00;
            duty_reg    <= `TBTC_WORD_RESET;
        end else begin
            duty_reg <= duty_final;
            if (seq_end) begin
                cyc_reg     <= '0;
                seq_idx_reg <= seq_idx_reg + 2'd1;
            end else begin
                cyc_reg <= cyc_reg + 17'd1;
            end
        end
    end

    // Hardware update wins over a software write of the baseline in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            base_reg <= `TBTC_WORD_RESET;
        else if (conv_end && seed_pend_reg)
            base_reg <= duty_final;
        else if (conv_end)
            base_reg <= ma_step(base_reg, duty_final, cfg_reg.avg_depth);
        else if (wr_fire && hit(paddr, `TBTC_IDX_BASE))
            base_reg <= pwdata[15:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            last_duty_reg <= `TBTC_WORD_RESET;
        else if (conv_end)
            last_duty_reg <= duty_final;
    end

    // Detection sets the flag whatever the filter setting; set beats a clearing write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            noise_flag_reg <= 1'b0;
        else if (state_reg == tbtc_pkg::TBTC_RUN && fe_sync_reg.noise)
            noise_flag_reg <= 1'b1;
        else if (wr_fire && hit(paddr, `TBTC_IDX_STATUS) && !pwdata[`TBTC_ST_NOISE])
            noise_flag_reg <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            trip_flag_reg <= 1'b0;
        else if (conv_end && {1'b0, duty_final} >= threshold)
            trip_flag_reg <= 1'b1;
        else if (wr_fire && hit(paddr, `TBTC_IDX_STATUS) && !pwdata[`TBTC_ST_TRIP])
            trip_flag_reg <= 1'b0;
    end

    // Events are one-cycle pulses after the result; wakeup only leaves auto mode.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trip_reg   <= 1'b0;
            wake_reg   <= 1'b0;
            active_reg <= 1'b0;
        end else begin
            trip_reg   <= conv_end && ({1'b0, duty_final} >= threshold);
            wake_reg   <= conv_end && auto_reg && ({1'b0, duty_final} >= threshold);
            active_reg <= (state_reg == tbtc_pkg::TBTC_RUN) && !conv_end;
        end
    end

    assign prdata      = prdata_reg;
    assign pready      = pready_reg;
    assign pslverr     = pslverr_reg;
    assign trip_event  = trip_reg;
    assign wake_event  = wake_reg;
    assign conv_active = active_reg;

    // Counts RUN cycles apart from the sequence counter, so the length check is independent.
    logic [18:0] run_len_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            run_len_reg <= '0;
        else if (state_reg != tbtc_pkg::TBTC_RUN)
            run_len_reg <= '0;
        else
            run_len_reg <= run_len_reg + 19'd1;
    end

    sequence s_cfg_write;
        wr_fire && hit(paddr, `TBTC_IDX_CFGC);
    endsequence

    sequence s_conv_end;
        conv_end;
    endsequence

    a_cfg_write_store: assert property (@(posedge pclk) disable iff (!presetn)
        s_cfg_write |=> cfg_reg == $past(pwdata[7:0]))
        else $error("configuration write not stored");

    a_seq_len_exact: assert property (@(posedge pclk) disable iff (!presetn)
        s_conv_end |-> run_len_reg
            == 19'(seq_cycles(cfg_reg.seq_len)) * (19'(repeat_count_reg) + 19'd1) - 19'd1)
        else $error("conversion did not end at its cycle count");

    a_repeat_runs: assert property (@(posedge pclk) disable iff (!presetn)
        seq_end && seq_idx_reg != repeat_count_reg
            |=> state_reg == tbtc_pkg::TBTC_RUN && cyc_reg == 17'd0)
        else $error("sequence not repeated with the same count");

    a_seed_load: assert property (@(posedge pclk) disable iff (!presetn)
        s_conv_end ##0 seed_pend_reg |=> base_reg == $past(duty_final))
        else $error("baseline not seeded from first result");

    a_avg_update: assert property (@(posedge pclk) disable iff (!presetn)
        s_conv_end ##0 !seed_pend_reg |=>
            base_reg == ma_step($past(base_reg), $past(duty_final), $past(cfg_reg.avg_depth)))
        else $error("baseline average not updated");

    a_trip_compare: assert property (@(posedge pclk) disable iff (!presetn)
        s_conv_end |=> trip_event == ($past({1'b0, duty_final}) >=
            ($past(cfg_reg.relative_threshold_select)
             ? {1'b0, $past(thd_reg)} + {1'b0, $past(base_reg)} : {1'b0, $past(thd_reg)})))
        else $error("trip event disagrees with threshold");

    a_filter_skip: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == tbtc_pkg::TBTC_RUN && filt_on && !conv_end
            |=> duty_reg == $past(duty_reg))
        else $error("filtered sample was counted");

    a_noise_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == tbtc_pkg::TBTC_RUN && fe_sync_reg.noise |=> noise_flag_reg)
        else $error("noise flag not set");

    a_noise_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        noise_flag_reg && !(wr_fire && hit(paddr, `TBTC_IDX_STATUS)) |=> noise_flag_reg)
        else $error("noise flag dropped without software clear");
endmodule

/* dv/tbtc_fe_model.sv */
// Behavioural analog front end: comparator output and noise detector of one electrode.
`timescale 1ns/1ps
module tbtc_fe_model (
    input  wire logic          pclk,
    input  wire logic          touched,
    input  wire logic          noisy,
    output tbtc_pkg::tbtc_fe_t fe
);
    // The comparator idles high, so only a loaded electrode adds to the low count.
    initial fe = 2'b10;
    always @(posedge pclk) begin
        fe.sense <= ~touched;
        fe.noise <= noisy;
    end
endmodule

/* dv/tb.sv */
// Self-checking bench for the touch channel configuration block.
`timescale 1ns/1ps
`include "tbtc_defines.svh"
module tb;
    localparam int SH = 8;
    logic               pclk;
    logic               presetn;
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [17:0]        paddr;
    logic [31:0]        pwdata;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic               trip_event;
    logic               wake_event;
    logic               conv_active;
    logic               touched;
    logic               noisy;
    logic               trip_seen;
    logic               wake_seen;
    logic               e;
    logic [31:0]        q;
    logic [31:0]        d;
    logic [31:0]        x;
    logic [33:0]        tbl [5];
    int                 mismatches;
    int                 cmp_count;
    int                 cyc;
    tbtc_pkg::tbtc_fe_t fe;

    tbtc_top #(.SEQ_SHIFT(SH)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .sense_in(fe.sense),
        .noise_in(fe.noise), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trip_event(trip_event), .wake_event(wake_event), .conv_active(conv_active));
    tbtc_fe_model i_fe (.pclk(pclk), .touched(touched), .noisy(noisy), .fe(fe));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    function automatic logic [31:0] rnd();
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    function automatic logic [31:0] cycles(input int k);
        logic [31:0] c;
        case (k)
            4: c = 32'h0000_3000;
            5: c = 32'h0000_4000;
            6: c = 32'h0000_8000;
            7: c = 32'h0001_0000;
            default: c = 32'h0000_0400 << k;
        endcase
        return c >> SH;
    endfunction

    // Baseline after one moving-average step of the given depth code.
    function automatic logic [31:0] avg(input int b, input int dv, input int dep);
        return b + ((dv - b) >>> (5 + dep));
    endfunction

    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] dat);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= dat;
        @(posedge pclk);
        penable <= 1'b1;
        // Read right after an edge, these are the values the slave showed at that edge.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [31:0] dat);
        apb(1'b1, idx, dat);
    endtask

    task automatic rdc(input logic [15:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0000_0000);
        chk(q, exp);
    endtask

    // The event pulses share the edge on which the busy level falls, so both are caught there.
    task automatic wait_conv();
        do begin
            @(negedge pclk);
        end while (conv_active !== 1'b1);
        do begin
            @(negedge pclk);
        end while (conv_active !== 1'b0);
        trip_seen = trip_event;
        wake_seen = wake_event;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            mismatches++;
            close_out();
        end
    end

    initial begin
        x = 32'h0000_001A;
        mismatches = 0;
        cmp_count = 0;
        cyc = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 18'h0_0000;
        pwdata = 32'h0000_0000;
        touched = 1'b0;
        noisy = 1'b0;
        tbl[0] = {1'b0, 16'h0100, 16'h0100, 1'b1};
        tbl[1] = {1'b0, 16'h0100, 16'h0101, 1'b0};
        tbl[2] = {1'b1, 16'h0100, 16'h0000, 1'b1};
        tbl[3] = {1'b1, 16'h0100, 16'h0001, 1'b0};
        tbl[4] = {1'b1, 16'hFFF0, 16'h0020, 1'b0};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`TBTC_IDX_CFGC, 32'h0000_0000);
        apb(1'b0, 16'hFFFF, 32'h0000_0000);
        chk(e, 1'b1);
        chk(q, 32'h0000_0000);
        repeat (6) begin
            d = rnd();
            wr(`TBTC_IDX_CFGC, d);
            rdc(`TBTC_IDX_CFGC, {24'h00_0000, d[7:0]});
        end
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`TBTC_IDX_CFGC, 32'h0000_0000);
        touched <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            noisy <= i[0];
            wr(`TBTC_IDX_CFGC, i * 8 + i[1]);
            wr(`TBTC_IDX_CTRL, i % 4 * 4 + 2);
            wait_conv();
            noisy <= 1'b0;
            rdc(`TBTC_IDX_DUTY, cycles(i) * (i % 4 + 1));
            apb(1'b0, `TBTC_IDX_STATUS, 32'h0000_0000);
            chk(q[0], i[0]);
            wr(`TBTC_IDX_STATUS, 32'h0000_0000);
        end
        apb(1'b0, `TBTC_IDX_STATUS, 32'h0000_0000);
        chk(q[0], 1'b0);
        for (int i = 0; i < 4; i++) begin
            wr(`TBTC_IDX_CFGC, i * 64 + 56);
            wr(`TBTC_IDX_BASE, 32'h0000_0000);
            wr(`TBTC_IDX_CTRL, 32'h0000_0002);
            wait_conv();
            rdc(`TBTC_IDX_BASE, avg(0, cycles(7), i));
        end
        foreach (tbl[k]) begin
            wr(`TBTC_IDX_CFGC, 56 + 2 * tbl[k][33]);
            wr(`TBTC_IDX_BASE, tbl[k][32:17]);
            wr(`TBTC_IDX_THD, tbl[k][16:1]);
            wr(`TBTC_IDX_CTRL, 32'h0000_0002);
            wait_conv();
            chk(trip_seen, tbl[k][0]);
            chk(wake_seen, 1'b0);
        end
        wr(`TBTC_IDX_THD, 32'h0000_0000);
        wr(`TBTC_IDX_CFGC, 32'h0000_003C);
        wr(`TBTC_IDX_BASE, 32'h0000_1234);
        wr(`TBTC_IDX_CTRL, 32'h0000_0001);
        wait_conv();
        chk(wake_seen, 1'b1);
        rdc(`TBTC_IDX_BASE, cycles(7));
        noisy <= 1'b1;
        wr(`TBTC_IDX_CFGC, 32'h0000_003D);
        wait_conv();
        wait_conv();
        rdc(`TBTC_IDX_DUTY, 32'h0000_0000);
        wr(`TBTC_IDX_CFGC, 32'h0000_003C);
        wait_conv();
        wait_conv();
        rdc(`TBTC_IDX_DUTY, cycles(7));
        apb(1'b0, `TBTC_IDX_STATUS, 32'h0000_0000);
        chk(q[0], 1'b1);
        noisy <= 1'b0;
        wr(`TBTC_IDX_CTRL, 32'h0000_0000);
        wait_conv();
        wr(`TBTC_IDX_CFGC, 32'h0000_0038);
        wr(`TBTC_IDX_BASE, 32'h0000_0040);
        wr(`TBTC_IDX_CTRL, 32'h0000_0001);
        wait_conv();
        rdc(`TBTC_IDX_BASE, avg(32'h0000_0040, cycles(7), 0));
        wr(`TBTC_IDX_CTRL, 32'h0000_0000);
        close_out();
    end
endmodule
